// ---- hdl/pmc_proc_end.sv ----
// processor end: issues read and write memory cycles
`timescale 1ns/1ns
`default_nettype none
`include "pmc_regs.svh"
module pmc_proc_end #(
   parameter int AW = 16,
   parameter int DW = 16
) (
   input  wire logic          i_mclk,     // common clock
   input  wire logic          i_srst,     // sync reset
   input  wire logic          i_ce,       // clock enable
   input  wire logic          i_req,      // start a cycle
   input  wire logic          i_rnw,      // 1 = read
   input  wire logic [AW-1:0] i_addr,     // target address
   input  wire logic [DW-1:0] i_wdata,    // write data
   output logic               o_busy,     // cycle running
   output logic               o_done,     // one-cycle completion
   output logic [DW-1:0]      o_rdata,    // latched read data
   pmc_bus_if.proc            bus         // shared bus
);
   import pmc_pkg::*;
   localparam logic [3:0] STRL = 4'(`PMC_STROBE_LOW_CYC); // strobe width sets cycle length
   pmc_proc_state_t st_q, st_d;
   logic [AW-1:0] addr_q, addr_d;         // held address
   logic [DW-1:0] wd_q, wd_d;             // held write data
   logic          rnw_q, rnw_d;           // held direction
   logic          stm_q, stm_d;           // start strobe level
   logic          smc_q, smc_d;           // memory strobe level
   logic          drv_q, drv_d;           // data drive enable
   logic [3:0]    cnt_q, cnt_d;           // strobe low width
   logic [DW-1:0] rd_q, rd_d;             // read data latch
   logic          done_q, done_d;         // done pulse
   logic          busy_q, busy_d;         // cycle running, flopped for the port

   // next-state for the cycle sequencer
   always_comb begin
      st_d = st_q; addr_d = addr_q; wd_d = wd_q; rnw_d = rnw_q;
      stm_d = stm_q; smc_d = smc_q; drv_d = drv_q; cnt_d = cnt_q;
      rd_d = rd_q; done_d = 1'b0;
      unique case (st_q)
         PMC_PS_IDLE: begin
            if (i_req) begin
               // present address, direction, start low
               addr_d = i_addr; wd_d = i_wdata; rnw_d = i_rnw;
               stm_d = 1'b0; drv_d = ~i_rnw;
               st_d = PMC_PS_WAIT;
            end
         end
         PMC_PS_START: st_d = PMC_PS_WAIT;
         PMC_PS_WAIT: begin
            // strobe only once the device has acked
            if (!bus.memory_ack_n) begin
               smc_d = 1'b0; cnt_d = STRL; st_d = PMC_PS_STRL;
            end
         end
         PMC_PS_STRL: begin
            if (cnt_q <= 4'h1) begin
               smc_d = 1'b1; // strobe rising edge
               if (rnw_q) rd_d = bus.dev_data;
               st_d = PMC_PS_END;
            end else cnt_d = cnt_q - 4'h1;
         end
         PMC_PS_END: begin
            // release start, data after strobe high
            stm_d = 1'b1; drv_d = 1'b0; done_d = 1'b1;
            st_d = PMC_PS_IDLE;
         end
         default: st_d = PMC_PS_IDLE; // illegal codes recover
      endcase
      // taken from the next state so the flop matches the state it reports
      busy_d = (st_d != PMC_PS_IDLE);
   end

   // register the sequencer; common clock for both ends
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_q <= PMC_PS_IDLE; addr_q <= '0; wd_q <= '0; rnw_q <= 1'b1;
         stm_q <= 1'b1; smc_q <= 1'b1; drv_q <= 1'b0; cnt_q <= 4'h0;
         rd_q <= '0; done_q <= 1'b0;
         busy_q <= 1'b0;
      end else if (i_ce) begin
         st_q <= st_d; addr_q <= addr_d; wd_q <= wd_d; rnw_q <= rnw_d;
         stm_q <= stm_d; smc_q <= smc_d; drv_q <= drv_d; cnt_q <= cnt_d;
         rd_q <= rd_d; done_q <= done_d;
         busy_q <= busy_d;
      end
   end

   assign bus.addr                  = addr_q;
   assign bus.proc_data             = wd_q;
   assign bus.proc_data_oe          = drv_q;
   assign bus.read_not_write        = rnw_q;
   assign bus.cycle_start_strobe_n  = stm_q;
   assign bus.memory_strobe_n       = smc_q;
   assign bus.processor_bus_drive_n = ~drv_q;
   assign o_busy  = busy_q;
   assign o_done  = done_q;
   assign o_rdata = rd_q;
endmodule
`default_nettype wire

// ---- hdl/pmc_regs.svh ----
// timing and address constants for the processor memory-cycle bus
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH
`define PMC_CLK_PERIOD_NS   10
`define PMC_READ_CYCLE_NS   1125
`define PMC_READ_CYCLES     (`PMC_READ_CYCLE_NS / `PMC_CLK_PERIOD_NS)
`define PMC_STROBE_LOW_CYC  4
`define PMC_REG_SPACE_TOP   16'h0010
`endif

// ---- hdl/pmc_pkg.sv ----
// types shared by both ends of the memory-cycle bus
package pmc_pkg;
   // device-side cycle states
   typedef enum logic [1:0] {
      PMC_DS_IDLE  = 2'b00,
      PMC_DS_ACK   = 2'b01,
      PMC_DS_DONE  = 2'b10
   } pmc_dev_state_t;
   // processor-side cycle states
   typedef enum logic [2:0] {
      PMC_PS_IDLE  = 3'b000,
      PMC_PS_START = 3'b001,
      PMC_PS_WAIT  = 3'b010,
      PMC_PS_STRL  = 3'b011,
      PMC_PS_END   = 3'b100
   } pmc_proc_state_t;
endpackage

// ---- hdl/pmc_bus_if.sv ----
// shared processor bus between processor end and memory end
`timescale 1ns/1ns
`default_nettype none
interface pmc_bus_if #(parameter int AW = 16, parameter int DW = 16);
   logic [AW-1:0] addr;                 // address lines
   logic [DW-1:0] proc_data;            // processor-driven data
   logic          proc_data_oe;         // processor drives data
   logic [DW-1:0] dev_data;             // device-driven data
   logic          dev_data_oe;          // device drives data
   logic          read_not_write;       // direction, high = read
   logic          cycle_start_strobe_n; // cycle start, active low
   logic          memory_strobe_n;      // processor strobe, active low
   logic          memory_ack_n;         // device ack, active low
   logic          processor_bus_drive_n;// processor driving bus
   modport proc (output addr, proc_data, proc_data_oe, read_not_write,
                 cycle_start_strobe_n, memory_strobe_n, processor_bus_drive_n,
                 input dev_data, dev_data_oe, memory_ack_n);
   modport dev  (input addr, proc_data, proc_data_oe, read_not_write,
                 cycle_start_strobe_n, memory_strobe_n, processor_bus_drive_n,
                 output dev_data, dev_data_oe, memory_ack_n);
endinterface
`default_nettype wire

// ---- hdl/pmc_mem_end.sv ----
// memory end: decoder, register section and read/write memory
`timescale 1ns/1ns
`default_nettype none
`include "pmc_regs.svh"
module pmc_mem_end #(
   parameter int AW    = 16,
   parameter int DW    = 16,
   parameter int NREG  = 16,    // register section words
   parameter int MDEP  = 256    // read/write memory words
) (
   input  wire logic          i_mclk,      // common clock
   input  wire logic          i_srst,      // sync reset
   input  wire logic          i_ce,        // clock enable
   output logic               o_reg_sel,   // last cycle hit registers
   output logic               o_wr_pulse,  // one-cycle write stored
   pmc_bus_if.dev             bus          // shared bus
);
   import pmc_pkg::*;
   localparam logic [AW-1:0] REG_TOP = AW'(`PMC_REG_SPACE_TOP);
   logic [DW-1:0] regs [NREG];             // register section
   logic [DW-1:0] mem  [MDEP];             // read/write memory
   pmc_dev_state_t st_q, st_d;
   logic          ack_q, ack_d;            // ack, active high internally
   logic          oe_q, oe_d;              // read drive enable
   logic [DW-1:0] rd_q, rd_d;              // read data
   logic          sel_q, sel_d;            // register section hit
   logic          smc_q;                   // strobe, previous cycle
   logic          wr_q, wr_d;              // write pulse
   logic          strobe_rise;             // strobe rising edge

   // decoder: register section below the top, memory at the top and above
   function automatic logic is_reg(input logic [AW-1:0] a);
      return a < REG_TOP;
   endfunction

   assign strobe_rise = bus.memory_strobe_n & ~smc_q;

   // next-state for ack, drive and read data
   always_comb begin
      st_d = st_q; ack_d = ack_q; oe_d = oe_q; rd_d = rd_q;
      sel_d = sel_q; wr_d = 1'b0;
      unique case (st_q)
         PMC_DS_IDLE: begin
            if (!bus.cycle_start_strobe_n) begin
               sel_d = is_reg(bus.addr);
               if (bus.read_not_write) begin
                  // source drives data and ack goes low
                  rd_d = is_reg(bus.addr)
                       ? regs[bus.addr[$clog2(NREG)-1:0]]
                       : mem[bus.addr[$clog2(MDEP)-1:0]];
                  oe_d = 1'b1;
               end
               ack_d = 1'b1;
               st_d  = PMC_DS_ACK;
            end
         end
         PMC_DS_ACK: begin
            // hold read data until strobe back high
            if (strobe_rise) begin
               wr_d = ~bus.read_not_write;
               st_d = PMC_DS_DONE;
            end
         end
         PMC_DS_DONE: begin
            // release once the start strobe is gone
            if (bus.cycle_start_strobe_n) begin
               ack_d = 1'b0; oe_d = 1'b0; st_d = PMC_DS_IDLE;
            end
         end
         default: st_d = PMC_DS_IDLE; // illegal code recovers
      endcase
   end

   // register control state
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_q <= PMC_DS_IDLE; ack_q <= 1'b0; oe_q <= 1'b0; rd_q <= '0;
         sel_q <= 1'b0; smc_q <= 1'b1; wr_q <= 1'b0;
      end else if (i_ce) begin
         st_q <= st_d; ack_q <= ack_d; oe_q <= oe_d; rd_q <= rd_d;
         sel_q <= sel_d; smc_q <= bus.memory_strobe_n; wr_q <= wr_d;
      end
   end

   // storage written on the strobe rising edge; no reset by design
   always_ff @(posedge i_mclk) begin
      if (i_ce && st_q == PMC_DS_ACK && strobe_rise && !bus.read_not_write) begin
         if (sel_q) regs[bus.addr[$clog2(NREG)-1:0]] <= bus.proc_data;
         else mem[bus.addr[$clog2(MDEP)-1:0]] <= bus.proc_data;
      end
   end

   assign bus.dev_data     = rd_q;
   assign bus.dev_data_oe  = oe_q;
   assign bus.memory_ack_n = ~ack_q;
   assign o_reg_sel  = sel_q;
   assign o_wr_pulse = wr_q;
endmodule
`default_nettype wire

// ---- tb/pmc_bus_chk.sv ----
// concurrent checks on the shared memory-cycle bus between both ends
`timescale 1ns/1ns
`default_nettype none
module pmc_bus_chk #(
   parameter int DW = 16
) (
   input wire logic        i_mclk,
   input wire logic        i_srst,
   input wire logic [DW-1:0] dev_data,
   input wire logic        dev_data_oe,
   input wire logic        proc_data_oe,
   input wire logic        read_not_write,
   input wire logic        cycle_start_strobe_n,
   input wire logic        memory_strobe_n,
   input wire logic        memory_ack_n,
   input wire logic        processor_bus_drive_n
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   // decoder must answer one cycle after the start strobe
   property p_ack; $fell(cycle_start_strobe_n) |=> !memory_ack_n; endproperty
   a_ack: assert property (p_ack) else $error("ack not given after start");
   // read source drives while acknowledged
   property p_rd_oe; !memory_ack_n && read_not_write |-> dev_data_oe; endproperty
   a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
   // data still driven and steady when the strobe rises
   property p_rd_hold;
      $rose(memory_strobe_n) && read_not_write |-> dev_data_oe && $stable(dev_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped early");
   // processor owns the bus for the whole write
   property p_wr_own;
      !read_not_write && !cycle_start_strobe_n |-> proc_data_oe && !processor_bus_drive_n;
   endproperty
   a_wr_own: assert property (p_wr_own) else $error("write data not held");
   // strobe only after the acknowledge
   property p_strb_ack; $fell(memory_strobe_n) |-> !memory_ack_n; endproperty
   a_strb_ack: assert property (p_strb_ack) else $error("strobe before ack");
   // strobe low exactly four cycles
   property p_strb_w; $fell(memory_strobe_n) |=> (!memory_strobe_n)[*3] ##1 memory_strobe_n;
   endproperty
   a_strb_w: assert property (p_strb_w) else $error("strobe width wrong");
   // cycle length from start low to start high
   property p_len; $fell(cycle_start_strobe_n) |-> ##7 $rose(cycle_start_strobe_n);
   endproperty
   a_len: assert property (p_len) else $error("cycle length wrong");
   // ack and device drive released one cycle after the end
   property p_rel; $rose(cycle_start_strobe_n) |=> memory_ack_n && !dev_data_oe; endproperty
   a_rel: assert property (p_rel) else $error("bus not released");
   c_rd: cover property ($fell(cycle_start_strobe_n) && read_not_write);
   c_wr: cover property ($fell(cycle_start_strobe_n) && !read_not_write);
   c_b2b: cover property ($rose(cycle_start_strobe_n) ##[1:3] $fell(cycle_start_strobe_n));
endmodule
`default_nettype wire

// ---- tb/processor_memory_cycle_bus_test.sv ----
// testbench joining processor end and memory end over the shared bus
`timescale 1ns/1ns
`default_nettype none
module processor_memory_cycle_bus_test;
   logic        mclk = 0;
   logic        srst = 1;
   logic        ce = 1;
   logic        req = 0;
   logic        rnw = 1;
   logic [15:0] addr = 16'h0000;
   logic [15:0] wdata = 16'h0000;
   logic        done, reg_sel, wr_pulse, seen_wp, seen_rs, busy;
   logic [15:0] rdata;
   int          miscompares = 0;
   int          samples_checked = 0;
   pmc_bus_if #(.AW(16), .DW(16)) u_pmc_bus_if ();
   pmc_proc_end u_pmc_proc_end (.i_mclk(mclk), .i_srst(srst), .i_ce(ce), .i_req(req),
      .i_rnw(rnw), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
      .o_rdata(rdata), .bus(u_pmc_bus_if));
   pmc_mem_end u_pmc_mem_end (.i_mclk(mclk), .i_srst(srst), .i_ce(ce),
      .o_reg_sel(reg_sel), .o_wr_pulse(wr_pulse), .bus(u_pmc_bus_if));
   pmc_bus_chk u_pmc_bus_chk (.i_mclk(mclk), .i_srst(srst),
      .dev_data(u_pmc_bus_if.dev_data), .dev_data_oe(u_pmc_bus_if.dev_data_oe),
      .proc_data_oe(u_pmc_bus_if.proc_data_oe), .read_not_write(u_pmc_bus_if.read_not_write),
      .cycle_start_strobe_n(u_pmc_bus_if.cycle_start_strobe_n),
      .memory_strobe_n(u_pmc_bus_if.memory_strobe_n), .memory_ack_n(u_pmc_bus_if.memory_ack_n),
      .processor_bus_drive_n(u_pmc_bus_if.processor_bus_drive_n));
   // 100 MHz clock
   initial begin
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      if (miscompares == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // one cycle; done, pulse and decode sampled mid-period, away from the edge
   task automatic cyc(input logic r, input logic [15:0] a, input logic [15:0] d);
      int n;
      n = 0;
      req <= 1'b1;
      rnw <= r;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      req <= 1'b0;
      @(negedge mclk);
      chk("busy_run", 16'h0001, {15'h0000, busy});
      while (done !== 1'b1 && n < 40) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 40) chk("done", 16'h0001, 16'h0000);
      chk("busy_end", 16'h0000, {15'h0000, busy});
      seen_wp = wr_pulse;
      seen_rs = reg_sel;
      @(posedge mclk);
   endtask
   // write then read one location, checking decode and readback
   task automatic t_rw(input logic [15:0] a, input logic [15:0] d, input logic rs);
      cyc(1'b0, a, d);
      chk("wr_pulse", 16'h0001, {15'h0000, seen_wp});
      chk("reg_sel_w", {15'h0000, rs}, {15'h0000, seen_rs});
      cyc(1'b1, a, 16'h0000);
      chk("rdata", d, rdata);
      chk("wp_read", 16'h0000, {15'h0000, seen_wp});
      chk("reg_sel_r", {15'h0000, rs}, {15'h0000, seen_rs});
   endtask
   // back-to-back writes then reads; neighbours must not clobber
   task automatic t_b2b();
      for (int i = 0; i < 4; i++) cyc(1'b0, 16'h0040 + 16'(i), 16'hC0DE ^ 16'(i));
      for (int i = 0; i < 4; i++) begin
         cyc(1'b1, 16'h0040 + 16'(i), 16'h0000);
         chk("b2b_rdata", 16'hC0DE ^ 16'(i), rdata);
      end
   endtask
   // a request while a cycle runs is dropped; the stored word survives
   task automatic t_refuse();
      cyc(1'b0, 16'h0050, 16'h1357);
      fork
         cyc(1'b1, 16'h0050, 16'h0000);
         begin
            repeat (3) @(posedge mclk);
            req <= 1'b1;
            rnw <= 1'b0;
            wdata <= 16'hDEAD;
            @(posedge mclk);
            req <= 1'b0;
         end
      join
      chk("refuse_rdata", 16'h1357, rdata);
      chk("refuse_wp", 16'h0000, {15'h0000, seen_wp});
      cyc(1'b1, 16'h0050, 16'h0000);
      chk("refuse_keep", 16'h1357, rdata);
   endtask
   // with the enable low a request is not taken and the bus stays idle
   task automatic t_freeze();
      ce <= 1'b0;
      req <= 1'b1;
      rnw <= 1'b1;
      addr <= 16'h0050;
      repeat (3) @(posedge mclk);
      req <= 1'b0;
      @(posedge mclk);
      ce <= 1'b1;
      repeat (3) @(negedge mclk);
      chk("frozen_busy", 16'h0000, {15'h0000, busy});
      chk("frozen_start", 16'h0001, {15'h0000, u_pmc_bus_if.cycle_start_strobe_n});
      @(posedge mclk);
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      @(posedge mclk);
      t_rw(16'h0020, 16'hA55A, 1'b0);
      t_rw(16'h000F, 16'h1234, 1'b1);
      t_rw(16'h0010, 16'h5678, 1'b0);
      t_rw(16'h0000, 16'hFFFF, 1'b1);
      t_b2b();
      t_refuse();
      t_freeze();
      conclude();
   end
   // watchdog well beyond the roughly two hundred cycles the tests need
   initial begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      conclude();
   end
endmodule
`default_nettype wire
